// ---- hw/rcc_consts.svh ----
/*
 * Constants of the calendar count block: register offsets, count limits
 * and the reset value of the reserved weekday nibble.
 * Assumes it is included by bare name wherever the block needs a number.
 */
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH

// I/O addresses of the registers.
`define RCC_OFS_HOURS 8'he2
`define RCC_OFS_WEEKDAY 8'he3
`define RCC_OFS_MONTHDAY 8'he4
`define RCC_OFS_MTH 8'he5
`define RCC_OFS_YEAR 8'he6
`define RCC_OFS_HUNDREDYEAR 8'he7
`define RCC_OFS_ALARM_S 8'he8

// Upper limits in binary and packed BCD form.
`define RCC_HOURS_MAX_BIN 8'h17
`define RCC_HOURS_MAX_BCD 8'h23
`define RCC_WEEKDAY_MAX 8'h07
`define RCC_MTH_MAX_BIN 8'h0c
`define RCC_MTH_MAX_BCD 8'h12
`define RCC_YEAR_MAX_BIN 8'h63
`define RCC_YEAR_MAX_BCD 8'h99
`define RCC_DAYS31_BIN 8'h1f
`define RCC_DAYS30_BIN 8'h1e
`define RCC_DAYS28_BIN 8'h1c
`define RCC_DAYS31_BCD 8'h31
`define RCC_DAYS30_BCD 8'h30
`define RCC_DAYS29_BCD 8'h29
`define RCC_DAYS28_BCD 8'h28

// Lower limits: hours and years start at zero, calendar days at one.
`define RCC_MIN_ZERO 8'h00
`define RCC_MIN_ONE 8'h01

// Field positions and reset value of the reserved weekday nibble.
`define RCC_WEEKDAY_RSVD_HI 7
`define RCC_WEEKDAY_RSVD_LO 4
`define RCC_WEEKDAY_RSVD_RST 4'h0

`endif

// ---- hw/rcc_pkg.sv ----
/*
 * Types shared by the calendar count block.
 * Assumes rcc_consts.svh carries the numbers.
 */
package rcc_pkg;
    typedef logic [7:0] rcc_byte_t;
    // Index of each counter in the ripple chain.
    typedef enum logic [5:0] {
        RCC_IDX_HOURS = 6'h01,
        RCC_IDX_WEEKDAY = 6'h02,
        RCC_IDX_MONTHDAY = 6'h04,
        RCC_IDX_MTH = 6'h08,
        RCC_IDX_YEAR = 6'h10,
        RCC_IDX_HUNDREDYEAR = 6'h20
    } rcc_idx_t;
endpackage

// ---- hw/rcc_digit.sv ----
/*
 * One calendar counter step: the next value of a binary or packed BCD
 * count and whether it wraps. Purely combinational.
 * Assumes the limits given match the format selected.
 */
`timescale 1ns/10ps
module rcc_digit
    import rcc_pkg::*;
(
    // Present value and limits.
    input wire rcc_byte_t val_in,
    input wire rcc_byte_t max_in,
    input wire rcc_byte_t min_in,
    input wire logic bcd_in,
    // Step result.
    output rcc_byte_t nxt_out,
    output logic wrap_out
);
    wire ones_nine = (val_in[3:0] >= 4'h9);

    // A value at or past the limit wraps, so a stray write cannot run away.
    assign wrap_out = (val_in >= max_in);
    // In BCD the ones digit carries into the tens digit after nine.
    assign nxt_out = wrap_out ? min_in :
                     (bcd_in && ones_nine) ? {val_in[7:4] + 4'h1, 4'h0} :
                     val_in + 8'h01;
endmodule

// ---- hw/rcc_calendar.sv ----
/*
 * Calendar count registers of the real-time clock: hours, weekday,
 * monthday, month, year, hundred-year counts and alarm seconds set-point.
 * Assumes a CPU I/O strobe bus on CLOCK_IN, and that the unlock gate,
 * format select and the hour carry come from logic on the same clock.
 */
// Behaviour
// - hours count 0..23, BCD tens 0..2.
// - weekday 1..7 in low nibble, upper reads zero.
// - weekday, monthday, month start and wrap at one.
// - monthday count 1..31, BCD tens 0..3.
// - month count 1..12, BCD tens 0..1.
// - year count 0..99.
// - hundred-year count 0..99.
// - reset keeps counts, clears weekday upper nibble.
// - locked gate ignores count register writes.
// - format bit selects binary or packed BCD.
// - alarm seconds always writable, 0..59.
// - hours kept in 24-hour form only.
// - unlocked stops counting, allows writes; reset does not touch the gate, UNLOCK_IN.
// - leap-year February only in BCD format.
`timescale 1ns/10ps
`include "rcc_consts.svh"
module rcc_calendar
    import rcc_pkg::*;
#(
    parameter int NUM_CNT = 6
) (
    // Clock and reset.
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    // CPU I/O bus.
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    // Control from the clock control logic.
    input wire logic UNLOCK_IN,
    input wire logic BCD_EN_IN,
    input wire logic HOUR_TICK_IN
);
    rcc_byte_t cnt_q [NUM_CNT];
    rcc_byte_t nxt [NUM_CNT];
    rcc_byte_t max_v [NUM_CNT];
    rcc_byte_t min_v [NUM_CNT];
    rcc_byte_t ofs_v [NUM_CNT];
    logic [NUM_CNT-1:0] wrap;
    logic [NUM_CNT-1:0] inc;
    logic [NUM_CNT-1:0] wsel;
    rcc_byte_t alarm_s_q;
    rcc_byte_t rdata_d;
    rcc_byte_t rdata_q;

    // Leap test on a packed BCD pair: divisible by four.
    function automatic logic bcd_div4(input rcc_byte_t v);
        logic odd_tens;
        odd_tens = v[4];
        bcd_div4 = odd_tens ? (v[3:0] == 4'h2 || v[3:0] == 4'h6) :
                   (v[3:0] == 4'h0 || v[3:0] == 4'h4 || v[3:0] == 4'h8);
    endfunction

    // Month number decoded to binary, then its length in days.
    wire [3:0] mth_num = (BCD_EN_IN && cnt_q[3][4]) ? cnt_q[3][3:0] + 4'ha
                                                    : cnt_q[3][3:0];
    wire is_feb = (mth_num == 4'h2);
    wire is_thirty = (mth_num == 4'h4) || (mth_num == 4'h6) ||
                     (mth_num == 4'h9) || (mth_num == 4'hb);
    // Year 00 is a leap year only when the hundred-year count divides by four.
    wire leap = (cnt_q[4] == 8'h00) ? bcd_div4(cnt_q[5]) : bcd_div4(cnt_q[4]);
    // Binary mode has no leap-year correction: February is always 28 days.
    wire [7:0] days_bcd = is_feb ? (leap ? `RCC_DAYS29_BCD : `RCC_DAYS28_BCD) :
                          is_thirty ? `RCC_DAYS30_BCD : `RCC_DAYS31_BCD;
    wire [7:0] days_bin = is_feb ? `RCC_DAYS28_BIN :
                          is_thirty ? `RCC_DAYS30_BIN : `RCC_DAYS31_BIN;

    // Limits per counter follow the format bit.
    assign max_v[0] = BCD_EN_IN ? `RCC_HOURS_MAX_BCD : `RCC_HOURS_MAX_BIN;
    assign max_v[1] = `RCC_WEEKDAY_MAX;
    assign max_v[2] = BCD_EN_IN ? days_bcd : days_bin;
    assign max_v[3] = BCD_EN_IN ? `RCC_MTH_MAX_BCD : `RCC_MTH_MAX_BIN;
    assign max_v[4] = BCD_EN_IN ? `RCC_YEAR_MAX_BCD : `RCC_YEAR_MAX_BIN;
    assign max_v[5] = BCD_EN_IN ? `RCC_YEAR_MAX_BCD : `RCC_YEAR_MAX_BIN;
    assign min_v[0] = `RCC_MIN_ZERO;
    assign min_v[1] = `RCC_MIN_ONE;
    assign min_v[2] = `RCC_MIN_ONE;
    assign min_v[3] = `RCC_MIN_ONE;
    assign min_v[4] = `RCC_MIN_ZERO;
    assign min_v[5] = `RCC_MIN_ZERO;
    assign ofs_v[0] = `RCC_OFS_HOURS;
    assign ofs_v[1] = `RCC_OFS_WEEKDAY;
    assign ofs_v[2] = `RCC_OFS_MONTHDAY;
    assign ofs_v[3] = `RCC_OFS_MTH;
    assign ofs_v[4] = `RCC_OFS_YEAR;
    assign ofs_v[5] = `RCC_OFS_HUNDREDYEAR;

    // Ripple chain: weekday and monthday both step on the hours wrap.
    assign inc[0] = HOUR_TICK_IN && !UNLOCK_IN;
    assign inc[1] = inc[0] && wrap[0];
    assign inc[2] = inc[0] && wrap[0];
    assign inc[3] = inc[2] && wrap[2];
    assign inc[4] = inc[3] && wrap[3];
    assign inc[5] = inc[4] && wrap[4];

    genvar i;
    generate
        for (i = 0; i < NUM_CNT; i++) begin : g_cnt
            rcc_digit u_step (
                .val_in(cnt_q[i]),
                .max_in(max_v[i]),
                .min_in(min_v[i]),
                .bcd_in(BCD_EN_IN),
                .nxt_out(nxt[i]),
                .wrap_out(wrap[i])
            );
            // Writes land only while the gate is open.
            assign wsel[i] = WR_IN && UNLOCK_IN && (ADDR_IN == ofs_v[i]);
            // No general reset: counts survive a system reset by design.
            always_ff @(posedge CLOCK_IN) begin
                if (wsel[i]) begin
                    cnt_q[i] <= WDATA_IN;
                end else if (inc[i]) begin
                    cnt_q[i] <= nxt[i];
                end
                if (i == 1 && (RST_IN || wsel[i])) begin
                    // Reserved weekday bits are cleared on reset and on every write.
                    cnt_q[i][`RCC_WEEKDAY_RSVD_HI:`RCC_WEEKDAY_RSVD_LO] <=
                        `RCC_WEEKDAY_RSVD_RST;
                end
            end
        end
    endgenerate

    // The alarm set-point ignores the gate and is never reset.
    always_ff @(posedge CLOCK_IN) begin
        if (WR_IN && ADDR_IN == `RCC_OFS_ALARM_S) begin
            alarm_s_q <= WDATA_IN;
        end
    end

    // Read mux; unmapped addresses answer zero.
    always_comb begin
        rdata_d = 8'h00;
        for (int k = 0; k < NUM_CNT; k++) begin
            if (ADDR_IN == ofs_v[k]) begin
                rdata_d = cnt_q[k];
            end
        end
        if (ADDR_IN == `RCC_OFS_ALARM_S) begin
            rdata_d = alarm_s_q;
        end
    end

    // Read data is captured on the strobe and held until the next read; reset clears it.
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            rdata_q <= 8'h00;
        end else if (RD_IN) begin
            rdata_q <= rdata_d;
        end
    end
    assign RDATA_OUT = rdata_q;

    chk_locked_write_ignored:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (WR_IN && !UNLOCK_IN && !HOUR_TICK_IN && ADDR_IN == `RCC_OFS_YEAR)
        |=> $stable(cnt_q[4]))
    else $error("Year count changed on a locked write.");

    chk_unlock_stops_count:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (UNLOCK_IN && !WR_IN) |=> $stable(cnt_q[0]) && $stable(cnt_q[2]))
    else $error("Counts moved while the gate was open.");

    chk_weekday_upper_zero:
    assert property (@(posedge CLOCK_IN)
        $past(RST_IN) |-> cnt_q[1][7:4] == 4'h0)
    else $error("Weekday reserved nibble not zero after reset.");

    chk_hours_wrap_zero:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (inc[0] && !WR_IN && BCD_EN_IN && cnt_q[0] == 8'h23)
        |=> cnt_q[0] == 8'h00)
    else $error("Hours did not wrap from 23 to 00.");

    chk_month_wrap_one:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (inc[3] && !WR_IN && !BCD_EN_IN && cnt_q[3] == 8'h0c)
        |=> cnt_q[3] == 8'h01 && !$stable(cnt_q[4]))
    else $error("Month did not wrap to one with a year carry.");

    chk_feb_binary_28:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (inc[2] && !WR_IN && !BCD_EN_IN && cnt_q[3] == 8'h02 &&
         cnt_q[2] == 8'h1c) |=> cnt_q[2] == 8'h01)
    else $error("Binary February did not end at 28.");

    chk_leap_bcd_29:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (inc[2] && !WR_IN && BCD_EN_IN && cnt_q[3] == 8'h02 &&
         cnt_q[2] == 8'h28 && cnt_q[4] == 8'h04) |=> cnt_q[2] == 8'h29)
    else $error("BCD leap February skipped day 29.");

    chk_bcd_digit_carry:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (inc[4] && !WR_IN && BCD_EN_IN && cnt_q[4] == 8'h19)
        |=> cnt_q[4] == 8'h20)
    else $error("BCD year did not carry 19 to 20.");

    chk_century_carry:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (inc[4] && !WR_IN && !BCD_EN_IN && cnt_q[4] == 8'h63 &&
         cnt_q[5] == 8'h63) |=> cnt_q[4] == 8'h00 && cnt_q[5] == 8'h00)
    else $error("Year wrap did not advance the hundred-year count.");

    chk_alarm_always_write:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (WR_IN && ADDR_IN == `RCC_OFS_ALARM_S) |=> alarm_s_q == $past(WDATA_IN))
    else $error("Alarm seconds write was lost.");

    // A weekday at or past seven returns to one on the next step.
    chk_weekday_wrap_one:
    assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
        (inc[1] && !WR_IN && cnt_q[1] == 8'h07) |=> cnt_q[1] == 8'h01)
    else $error("Weekday did not wrap from seven to one.");
endmodule

// ---- verif/rcc_cpu_model.sv ----
/*
 * CPU side of the I/O strobe bus: single write and read cycles.
 * Assumes the block samples the strobes on the rising clock edge.
 */
`timescale 1ns/10ps
module rcc_cpu_model (
    // Bus clock.
    input wire logic clk_in,
    // Strobe bus towards the block.
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [7:0] rdata_in
);
    // Quiet bus at time zero.
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // One write; released data flips so a stale byte is never taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask

    // One read; data is registered, so it is settled by the next falling edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        d = rdata_in;
    endtask
endmodule

// ---- verif/testbench.sv ----
/*
 * Self-checking bench for the calendar count registers.
 * Assumes the CPU model drives the bus and the bench drives gate, format and carry.
 */
`timescale 1ns/10ps
module testbench;
    import rcc_pkg::*;
    typedef rcc_byte_t rcc_six_t [6];
    logic clk, rst, unlock, bcd, tick, wr, rd;
    logic [7:0] addr, wdata, rdata;
    int mismatches = 0;
    int cmp_count = 0;

    rcc_calendar uut (.CLOCK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .UNLOCK_IN(unlock),
        .BCD_EN_IN(bcd), .HOUR_TICK_IN(tick));
    rcc_cpu_model cpu (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd), .rdata_in(rdata));

    // 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input rcc_byte_t exp, input rcc_byte_t got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rdc(input rcc_byte_t a, input rcc_byte_t exp);
        rcc_byte_t d;
        cpu.rd(a, d);
        cmp($sformatf("register %h", a), exp, d);
    endtask

    // The six counts sit at consecutive addresses from hours upward.
    task automatic set6(input rcc_six_t v);
        for (int i = 0; i < 6; i++) begin
            cpu.wr(8'he2 + 8'(i), v[i]);
        end
    endtask

    task automatic chk6(input rcc_six_t v);
        for (int i = 0; i < 6; i++) begin
            rdc(8'he2 + 8'(i), v[i]);
        end
    endtask

    task automatic gate(input logic u, input logic b);
        @(negedge clk);
        unlock = u;
        bcd = b;
    endtask

    task automatic step();
        @(negedge clk);
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
    endtask

    // Full ripple wrap in packed BCD.
    task automatic t_wrap_bcd();
        gate(1'b1, 1'b1);
        set6('{8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h05});
        gate(1'b0, 1'b1);
        step();
        chk6('{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h06});
    endtask

    // Full ripple wrap in binary, the hundred-year count wrapping too.
    task automatic t_wrap_bin();
        gate(1'b1, 1'b0);
        set6('{8'h17, 8'h07, 8'h1f, 8'h0c, 8'h63, 8'h63});
        gate(1'b0, 1'b0);
        step();
        chk6('{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00});
    endtask

    // BCD ones digit carries into the tens digit without a wrap.
    task automatic t_digit();
        gate(1'b1, 1'b1);
        set6('{8'h09, 8'h01, 8'h09, 8'h09, 8'h09, 8'h09});
        gate(1'b0, 1'b1);
        step();
        chk6('{8'h10, 8'h01, 8'h09, 8'h09, 8'h09, 8'h09});
    endtask

    // Runs one count step from the given counts in the given format.
    task automatic roll(input logic b, input rcc_six_t v);
        gate(1'b1, b);
        set6(v);
        gate(1'b0, b);
        step();
    endtask

    // BCD month ends: a thirty-day month, a year digit carry, a plain February.
    task automatic t_months();
        roll(1'b1, '{8'h23, 8'h07, 8'h30, 8'h04, 8'h19, 8'h05});
        chk6('{8'h00, 8'h01, 8'h01, 8'h05, 8'h19, 8'h05});
        roll(1'b1, '{8'h23, 8'h07, 8'h31, 8'h12, 8'h19, 8'h05});
        chk6('{8'h00, 8'h01, 8'h01, 8'h01, 8'h20, 8'h05});
        roll(1'b1, '{8'h23, 8'h07, 8'h28, 8'h02, 8'h00, 8'h19});
        chk6('{8'h00, 8'h01, 8'h01, 8'h03, 8'h00, 8'h19});
    endtask

    // February in a leap year: BCD keeps day 29, binary goes to March.
    task automatic t_leap();
        gate(1'b1, 1'b1);
        set6('{8'h23, 8'h03, 8'h28, 8'h02, 8'h04, 8'h20});
        gate(1'b0, 1'b1);
        step();
        chk6('{8'h00, 8'h04, 8'h29, 8'h02, 8'h04, 8'h20});
        gate(1'b1, 1'b0);
        set6('{8'h17, 8'h03, 8'h1c, 8'h02, 8'h04, 8'h14});
        gate(1'b0, 1'b0);
        step();
        chk6('{8'h00, 8'h04, 8'h01, 8'h03, 8'h04, 8'h14});
    endtask

    // Locked writes dropped, alarm always taken, unlocked carry ignored.
    task automatic t_lock();
        gate(1'b0, 1'b0);
        set6('{8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05});
        chk6('{8'h00, 8'h04, 8'h01, 8'h03, 8'h04, 8'h14});
        cpu.wr(8'he8, 8'h3b);
        rdc(8'he8, 8'h3b);
        rdc(8'hf0, 8'h00);
        gate(1'b1, 1'b0);
        step();
        chk6('{8'h00, 8'h04, 8'h01, 8'h03, 8'h04, 8'h14});
    endtask

    // Reset keeps the counts; weekday upper nibble stays zero.
    task automatic t_reset();
        gate(1'b1, 1'b1);
        set6('{8'h21, 8'hf6, 8'h30, 8'h11, 8'h98, 8'h19});
        rdc(8'he3, 8'h06);
        gate(1'b0, 1'b1);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk6('{8'h21, 8'h06, 8'h30, 8'h11, 8'h98, 8'h19});
        rdc(8'he8, 8'h3b);
    endtask

    // Main sequence after a 16-cycle reset.
    initial begin
        rst = 1'b1;
        unlock = 1'b0;
        bcd = 1'b0;
        tick = 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_wrap_bcd();
        t_wrap_bin();
        t_digit();
        t_months();
        t_leap();
        t_lock();
        t_reset();
        wrap_up();
    end

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end
endmodule
